// >>> sim/qdfd_host_model.sv
// Purpose: serial master model that reads out the diagnostic word
// Assumes: steps on core_clk edges, half clock given in core cycles
// Notes:   a released data line shows the inverse of its last value
module qdfd_host_model (
  input  wire logic core_clk,
  output logic      serial_cs_n,
  output logic      serial_clk,
  output logic      serial_rx_pin,
  input  wire logic serial_tx_pin_o,
  input  wire logic serial_tx_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last;
  wire  line = serial_tx_pin_oe ? serial_tx_pin_o : ~last;

  initial begin
    serial_cs_n = 1'b1;
    serial_clk = 1'b0;
    serial_rx_pin = 1'b0;
    last = 1'b0;
  end

  always @(posedge core_clk) begin
    if (serial_tx_pin_oe) begin
      last <= serial_tx_pin_o;
    end
  end

  // sel low keeps select high while the clock still toggles
  task automatic frame(input logic sel, input int half, input logic [15:0] txw,
                       output logic [15:0] rxw);
    rxw = '0;
    @(posedge core_clk);
    serial_cs_n <= ~sel;
    repeat (half + 2) @(posedge core_clk);
    for (int i = 15; i >= 0; i--) begin
      serial_rx_pin <= txw[i];
      repeat (half - 1) @(posedge core_clk);
      @(negedge core_clk);
      rxw[i] = line;
      @(posedge core_clk);
      serial_clk <= 1'b1;
      repeat (half) @(posedge core_clk);
      serial_clk <= 1'b0;
    end
    repeat (half) @(posedge core_clk);
    serial_cs_n <= 1'b1;
    serial_rx_pin <= ~serial_rx_pin;
  endtask
endmodule

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the quad driver fault diagnostics
// Assumes: short persistence filter, host model on the serial side
// Notes:   outputs sampled at the falling edge, apb answers at the access edge
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FL = 3;
  logic        core_clk, resetn, drive_enable, undervolt_rst, err;
  logic [3:0]  cmd, gnd_c, sup_c, open_c, therm, oc, out_drive;
  logic        serial_cs_n, serial_clk, serial_rx_pin, tx_o, tx_oe;
  logic [7:0]  paddr;
  logic        psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] pwdata, prdata, rd, r32;
  logic [15:0] rxw;
  int          mismatches, num_checks, seed;

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  qdfd_top #(.FILT_LEN(FL)) u_qdfd_top (
    .core_clk(core_clk), .resetn(resetn), .drive_cmd_one(cmd[0]), .drive_cmd_two(cmd[1]),
    .drive_cmd_three(cmd[2]), .drive_cmd_four(cmd[3]), .drive_enable(drive_enable),
    .undervolt_rst(undervolt_rst), .gnd_short_cmp(gnd_c), .supply_short_cmp(sup_c),
    .open_load_cmp(open_c), .thermal_sd(therm), .overcurrent_det(oc),
    .serial_cs_n(serial_cs_n), .serial_clk(serial_clk), .serial_rx_pin(serial_rx_pin),
    .serial_tx_pin_o(tx_o), .serial_tx_pin_oe(tx_oe), .out_drive(out_drive),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  qdfd_host_model u_qdfd_host_model (
    .core_clk(core_clk), .serial_cs_n(serial_cs_n), .serial_clk(serial_clk),
    .serial_rx_pin(serial_rx_pin), .serial_tx_pin_o(tx_o), .serial_tx_pin_oe(tx_oe));

  task automatic print_verdict;
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic settle(input int n);
    tick(n);
    @(negedge core_clk);
  endtask

  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      print_verdict;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(nm, rd, e);
  endtask

  // ground short ch0, supply short ch1, open load ch2 for n cycles
  task automatic pulse(input int n);
    tick(1);
    gnd_c <= 4'h1;
    sup_c <= 4'h2;
    open_c <= 4'h4;
    tick(n);
    gnd_c <= 4'h0;
    sup_c <= 4'h0;
    open_c <= 4'h0;
    settle(FL + 6);
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    print_verdict;
  end

  initial begin
    seed = 21053;
    mismatches = 0;
    num_checks = 0;
    resetn = 1'b0;
    {drive_enable, undervolt_rst, psel, penable, pwrite} = '0;
    {cmd, gnd_c, sup_c, open_c, therm, oc} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tick(20);
    resetn <= 1'b1;
    settle(1);
    chk("drive_rst", out_drive, 32'h0);
    chk("irq_rst", irq, 32'h0);
    rd_chk("diag_rst", qdfd_pkg::OFS_DIAG, 32'h0);
    apb(qdfd_pkg::OFS_IRQ_EN, 1'b1, 32'h0000FFFF);
    rd_chk("irq_en", qdfd_pkg::OFS_IRQ_EN, 32'h0000FFFF);
    apb(8'h20, 1'b0, 32'h0);
    chk("unmapped_err", err, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    tick(1);
    drive_enable <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      r32 = $random(seed);
      tick(1);
      cmd <= (i < 2) ? {4{i[0]}} : r32[3:0];
      settle(6);
      chk("drive", out_drive, cmd);
    end
    tick(1);
    cmd <= 4'hF;
    drive_enable <= 1'b0;
    settle(6);
    chk("drive_gated", out_drive, 32'h0);
    tick(1);
    drive_enable <= 1'b1;
    undervolt_rst <= 1'b1;
    settle(6);
    chk("drive_uv", out_drive, 32'h0);
    tick(1);
    undervolt_rst <= 1'b0;
    settle(6);
    chk("drive_back", out_drive, 32'hF);
    tick(1);
    oc <= 4'h1;
    settle(6);
    chk("oc_off", out_drive, 32'hE);
    tick(1);
    oc <= 4'h0;
    settle(6);
    chk("oc_held", out_drive, 32'hE);
    tick(1);
    cmd <= 4'hE;
    tick(6);
    cmd <= 4'hF;
    settle(6);
    chk("oc_restart", out_drive, 32'hF);
    pulse(FL - 1);
    rd_chk("diag_spike", qdfd_pkg::OFS_DIAG, 32'h0);
    tick(1);
    drive_enable <= 1'b0;
    pulse(FL + 6);
    rd_chk("diag_gated", qdfd_pkg::OFS_DIAG, 32'h0);
    tick(1);
    drive_enable <= 1'b1;
    therm <= 4'h8;
    tick(FL - 1);
    therm <= 4'h0;
    settle(5);
    rd_chk("diag_therm", qdfd_pkg::OFS_DIAG, 32'h8000);
    pulse(FL + 6);
    rd_chk("diag_faults", qdfd_pkg::OFS_DIAG, 32'h8421);
    rd_chk("irq_stat", qdfd_pkg::OFS_IRQ_STAT, 32'h8421);
    settle(0);
    chk("irq_on", irq, 32'h1);
    apb(qdfd_pkg::OFS_IRQ_EN, 1'b1, 32'h0);
    settle(1);
    chk("irq_masked", irq, 32'h0);
    apb(qdfd_pkg::OFS_IRQ_EN, 1'b1, 32'h0000FFFF);
    apb(qdfd_pkg::OFS_IRQ_CLR, 1'b1, 32'h0000FFFF);
    settle(1);
    chk("irq_clr", irq, 32'h0);
    rd_chk("stat_clr", qdfd_pkg::OFS_IRQ_STAT, 32'h0);
    apb(qdfd_pkg::OFS_DIAG, 1'b1, 32'h0);
    chk("ro_err", err, 32'h1);
    u_qdfd_host_model.frame(1'b0, 4, 16'hFFFF, rxw);
    settle(0);
    chk("tx_released", tx_oe, 32'h0);
    rd_chk("diag_kept", qdfd_pkg::OFS_DIAG, 32'h8421);
    r32 = $random(seed);
    u_qdfd_host_model.frame(1'b1, 4, r32[15:0], rxw);
    chk("readout", rxw, 32'h8421);
    settle(6);
    rd_chk("rx_word", qdfd_pkg::OFS_RX_WORD, {16'h0, r32[15:0]});
    rd_chk("diag_clr", qdfd_pkg::OFS_DIAG, 32'h0);
    u_qdfd_host_model.frame(1'b1, 4, 16'hA5C3, rxw);
    chk("readout_empty", rxw, 32'h0);
    settle(6);
    rd_chk("rx_word_two", qdfd_pkg::OFS_RX_WORD, 32'h0000A5C3);
    print_verdict;
  end
endmodule

// >>> src/qdfd_persist_filter.sv
// Purpose: persistence filter for one fault comparator
// Assumes: fault_in synchronised to clk
// Notes:   hit rises once LEN consecutive samples were high
module qdfd_persist_filter #(
  parameter int LEN = qdfd_pkg::FILT_LEN_DEF
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic run,
  input  wire logic fault_in,
  output logic      hit
);
  logic [LEN-1:0] shift_q;
  logic [LEN-1:0] shift_d;

  if (LEN < 2) begin : g_chk
    $error("filter length must be at least 2");
  end

  always_comb begin
    // filter held cleared while the enable is low
    shift_d = run ? {shift_q[LEN-2:0], fault_in} : '0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= '0;
    end else begin
      shift_q <= shift_d;
    end
  end

  assign hit = &shift_q;
endmodule

// >>> src/qdfd_pkg.sv
// Purpose: shared constants and types of the quad driver fault diagnostics
// Assumes: 4 channels, 4 fault kinds, 16 bit diagnostic word
// Notes:   diag bit index is channel * 4 + fault kind
// Overview of operation
// - each channel command switches its own output
// - chip select and resetn active low, other controls active high
// - serial clock rising edge, positive data logic
// - one enable gates all drives and filters
// - four fault kinds detected on every channel
// - faults must persist a preset cycle count
// - thermal shutdown sets its bit unfiltered
// - sixteen bit diagnostic word read serially
// - undervoltage reset forces all outputs off
// - overcurrent latches off until command retoggled; undervoltage reset also clears the latch
package qdfd_pkg;
  localparam int NCH    = 4;
  localparam int NKIND  = 4;
  localparam int DIAG_W = 16;

  localparam int KIND_GND    = 0;
  localparam int KIND_SUPPLY = 1;
  localparam int KIND_OPEN   = 2;
  localparam int KIND_THERM  = 3;

  localparam logic [7:0] OFS_DIAG     = 8'h00;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h0C;
  localparam logic [7:0] OFS_RX_WORD  = 8'h10;

  localparam logic [15:0] RST_DIAG    = 16'h0000;
  localparam logic [15:0] RST_IRQ     = 16'h0000;
  localparam logic [3:0]  RST_DRIVE   = 4'h0;

  localparam int FILT_LEN_DEF = 8;
  localparam int SYNC_W       = 29;

  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_SHIFT = 2'b01
  } qdfd_ser_e;

  function automatic int diag_idx(input int ch, input int kind);
    return ch * NKIND + kind;
  endfunction
endpackage

// >>> src/qdfd_ser_if.sv
// Purpose: link between the top and the serial shifter
// Assumes: all signals on core_clk, inputs already synchronised
// Notes:   cs_fall and cs_rise and sclk_rise are one-cycle pulses
interface qdfd_ser_if;
  logic        cs_fall;
  logic        cs_rise;
  logic        sclk_rise;
  logic        rx_bit;
  logic [15:0] load_word;
  logic        tx_bit;
  logic        active;
  logic [15:0] rx_word;
  modport ctl (output cs_fall, cs_rise, sclk_rise, rx_bit, load_word,
               input tx_bit, active, rx_word);
  modport ser (input cs_fall, cs_rise, sclk_rise, rx_bit, load_word,
               output tx_bit, active, rx_word);
endinterface

// >>> src/qdfd_serial_shift.sv
// Purpose: 16 bit serial readout shifter
// Assumes: strobes from qdfd_ser_if, already edge detected
// Notes:   msb first; shifts on each serial clock rising edge
module qdfd_serial_shift #(
  parameter int W = qdfd_pkg::DIAG_W
) (
  input  wire logic  clk,
  input  wire logic  resetn,
  qdfd_ser_if.ser    sif
);
  qdfd_pkg::qdfd_ser_e state_q;
  qdfd_pkg::qdfd_ser_e state_d;
  logic [W-1:0]        shift_q;
  logic [W-1:0]        shift_d;
  logic [W-1:0]        rxw_q;
  logic [W-1:0]        rxw_d;

  if (W != 16) begin : g_chk
    $error("serial word must be 16 bits");
  end

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    rxw_d   = rxw_q;
    unique case (state_q)
      qdfd_pkg::SER_IDLE: begin
        if (sif.cs_fall) begin
          state_d = qdfd_pkg::SER_SHIFT;
          shift_d = sif.load_word;
        end
      end
      qdfd_pkg::SER_SHIFT: begin
        if (sif.cs_rise) begin
          state_d = qdfd_pkg::SER_IDLE;
          rxw_d   = shift_q;
        end else if (sif.sclk_rise) begin
          shift_d = {shift_q[W-2:0], sif.rx_bit};
        end
      end
      default: state_d = qdfd_pkg::SER_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= qdfd_pkg::SER_IDLE;
      shift_q <= '0;
      rxw_q   <= '0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      rxw_q   <= rxw_d;
    end
  end

  assign sif.tx_bit  = shift_q[W-1];
  assign sif.active  = (state_q == qdfd_pkg::SER_SHIFT);
  assign sif.rx_word = rxw_q;

  property p_cs_starts;
    @(posedge clk) disable iff (!resetn)
      (state_q == qdfd_pkg::SER_IDLE && sif.cs_fall) |=> (state_q == qdfd_pkg::SER_SHIFT);
  endproperty
  a_cs_starts: assert property (p_cs_starts) else $error("select did not start frame");

  property p_rise_shift;
    @(posedge clk) disable iff (!resetn)
      (state_q == qdfd_pkg::SER_SHIFT && sif.sclk_rise && !sif.cs_rise)
        |=> (shift_q[0] == $past(sif.rx_bit) && shift_q[W-1] == $past(shift_q[W-2]));
  endproperty
  a_rise_shift: assert property (p_rise_shift) else $error("no shift on clock rise");
endmodule

// >>> src/qdfd_top.sv
// Purpose: quad low-side driver control with fault diagnostics
// Assumes: all pins except the bus and resetn asynchronous to core_clk; serial clock well below core_clk/6
// Notes:   diagnostic bits are sticky and clear when a readout starts
module qdfd_top #(
  parameter int FILT_LEN = qdfd_pkg::FILT_LEN_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        drive_cmd_one,
  input  wire logic        drive_cmd_two,
  input  wire logic        drive_cmd_three,
  input  wire logic        drive_cmd_four,
  input  wire logic        drive_enable,
  input  wire logic        undervolt_rst,
  input  wire logic [3:0]  gnd_short_cmp,
  input  wire logic [3:0]  supply_short_cmp,
  input  wire logic [3:0]  open_load_cmp,
  input  wire logic [3:0]  thermal_sd,
  input  wire logic [3:0]  overcurrent_det,
  input  wire logic        serial_cs_n,
  input  wire logic        serial_clk,
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_pin_o,
  output logic             serial_tx_pin_oe,
  output logic [3:0]       out_drive,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  localparam int NCH = qdfd_pkg::NCH;
  localparam int SW  = qdfd_pkg::SYNC_W;

  if (FILT_LEN < 2 || FILT_LEN > 64) begin : g_chk
    $error("FILT_LEN out of range");
  end

  // two-stage synchroniser on every driver, fault and serial pin, third stage for edges
  // select resets to its idle high level: no false select edge
  localparam logic [SW-1:0] SYNC_IDLE = SW'(3'h4);
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [2:0]    edge_q;

  assign pin_raw = {overcurrent_det, thermal_sd, open_load_cmp, supply_short_cmp,
                    gnd_short_cmp, drive_cmd_four, drive_cmd_three, drive_cmd_two,
                    drive_cmd_one, drive_enable, undervolt_rst,
                    serial_cs_n, serial_clk, serial_rx_pin};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
      edge_q  <= 3'h4;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      edge_q  <= sync2_q[2:0];
    end
  end

  logic       rx_s;
  logic       sclk_s;
  logic       cs_n_s;
  logic       uv_s;
  logic       en_s;
  logic [3:0] cmd_s;
  logic [3:0] gnd_s;
  logic [3:0] sup_s;
  logic [3:0] open_s;
  logic [3:0] therm_s;
  logic [3:0] oc_s;

  assign rx_s    = sync2_q[0];
  assign sclk_s  = sync2_q[1];
  assign cs_n_s  = sync2_q[2];
  assign uv_s    = sync2_q[3];
  assign en_s    = sync2_q[4];
  assign cmd_s   = sync2_q[8:5];
  assign gnd_s   = sync2_q[12:9];
  assign sup_s   = sync2_q[16:13];
  assign open_s  = sync2_q[20:17];
  assign therm_s = sync2_q[24:21];
  assign oc_s    = sync2_q[28:25];

  // serial readout
  qdfd_ser_if sif ();

  logic [15:0] diag_q;
  logic [15:0] diag_d;
  logic [15:0] set_vec;

  assign sif.cs_fall   = edge_q[2] && !cs_n_s;
  assign sif.cs_rise   = !edge_q[2] && cs_n_s;
  assign sif.sclk_rise = !edge_q[1] && sclk_s && !cs_n_s;
  assign sif.rx_bit    = rx_s;
  assign sif.load_word = diag_q | set_vec;

  qdfd_serial_shift #(
    .W (qdfd_pkg::DIAG_W)
  ) u_ser (
    .clk    (core_clk),
    .resetn (resetn),
    .sif    (sif)
  );

  // released while deselected
  assign serial_tx_pin_o  = sif.tx_bit;
  assign serial_tx_pin_oe = sif.active && !cs_n_s;

  // fault filters: ground, supply, open per channel
  logic [3:0] hit_gnd;
  logic [3:0] hit_sup;
  logic [3:0] hit_open;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    qdfd_persist_filter #(.LEN(FILT_LEN)) u_fg (
      .clk (core_clk), .resetn (resetn), .run (en_s), .fault_in (gnd_s[c]),
      .hit (hit_gnd[c]));
    qdfd_persist_filter #(.LEN(FILT_LEN)) u_fs (
      .clk (core_clk), .resetn (resetn), .run (en_s), .fault_in (sup_s[c]),
      .hit (hit_sup[c]));
    qdfd_persist_filter #(.LEN(FILT_LEN)) u_fo (
      .clk (core_clk), .resetn (resetn), .run (en_s), .fault_in (open_s[c]),
      .hit (hit_open[c]));
  end

  always_comb begin
    set_vec = '0;
    for (int c = 0; c < NCH; c++) begin
      set_vec[qdfd_pkg::diag_idx(c, qdfd_pkg::KIND_GND)]    = hit_gnd[c];
      set_vec[qdfd_pkg::diag_idx(c, qdfd_pkg::KIND_SUPPLY)] = hit_sup[c];
      set_vec[qdfd_pkg::diag_idx(c, qdfd_pkg::KIND_OPEN)]   = hit_open[c];
      set_vec[qdfd_pkg::diag_idx(c, qdfd_pkg::KIND_THERM)]  = therm_s[c];
    end
  end

  // sticky diag bits, cleared on readout start, set wins
  always_comb begin
    diag_d = sif.cs_fall ? set_vec : (diag_q | set_vec);
  end

  // drive stage with overcurrent latch
  logic [3:0] oc_lat_q;
  logic [3:0] oc_lat_d;
  logic [3:0] drive_q;
  logic [3:0] drive_d;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      if (uv_s) begin
        oc_lat_d[c] = 1'b0;
      end else if (oc_s[c]) begin
        oc_lat_d[c] = 1'b1;
      end else if (!cmd_s[c]) begin
        oc_lat_d[c] = 1'b0;
      end else begin
        oc_lat_d[c] = oc_lat_q[c];
      end
    end
    drive_d = (uv_s || !en_s) ? qdfd_pkg::RST_DRIVE : (cmd_s & ~oc_lat_d);
  end

  assign out_drive = drive_q;

  // register bus and interrupt state
  logic [15:0] stat_q;
  logic [15:0] stat_d;
  logic [15:0] irqen_q;
  logic [15:0] irqen_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        err_q;
  logic        err_d;
  logic [15:0] new_set;
  logic        wr_acc;
  logic        setup;
  logic        mapped;

  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite;
  assign new_set = set_vec & ~diag_q;

  function automatic logic is_mapped(input logic [7:0] a, input logic wr);
    unique case (a)
      qdfd_pkg::OFS_DIAG, qdfd_pkg::OFS_IRQ_STAT,
      qdfd_pkg::OFS_RX_WORD: return !wr;
      qdfd_pkg::OFS_IRQ_CLR: return wr;
      qdfd_pkg::OFS_IRQ_EN:  return 1'b1;
      default:               return 1'b0;
    endcase
  endfunction

  assign mapped = is_mapped(paddr, pwrite);

  always_comb begin
    logic [15:0] clr;
    clr      = '0;
    irqen_d  = irqen_q;
    prdata_d = prdata_q;
    err_d    = err_q;
    if (wr_acc && mapped && paddr == qdfd_pkg::OFS_IRQ_CLR) begin
      clr = pwdata[15:0];
    end
    if (wr_acc && mapped && paddr == qdfd_pkg::OFS_IRQ_EN) begin
      irqen_d = pwdata[15:0];
    end
    // event arriving with its clear is kept
    stat_d = (stat_q & ~clr) | new_set;
    if (setup) begin
      err_d    = !mapped;
      prdata_d = '0;
      if (!pwrite) begin
        unique case (paddr)
          qdfd_pkg::OFS_DIAG:     prdata_d = {16'h0000, diag_q};
          qdfd_pkg::OFS_IRQ_STAT: prdata_d = {16'h0000, stat_q};
          qdfd_pkg::OFS_IRQ_EN:   prdata_d = {16'h0000, irqen_q};
          qdfd_pkg::OFS_RX_WORD:  prdata_d = {16'h0000, sif.rx_word};
          default:                prdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      diag_q   <= qdfd_pkg::RST_DIAG;
      oc_lat_q <= '0;
      drive_q  <= qdfd_pkg::RST_DRIVE;
      stat_q   <= qdfd_pkg::RST_IRQ;
      irqen_q  <= qdfd_pkg::RST_IRQ;
      prdata_q <= '0;
      err_q    <= 1'b0;
    end else begin
      diag_q   <= diag_d;
      oc_lat_q <= oc_lat_d;
      drive_q  <= drive_d;
      stat_q   <= stat_d;
      irqen_q  <= irqen_d;
      prdata_q <= prdata_d;
      err_q    <= err_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_q;
  assign irq     = |(stat_q & irqen_q);

  // checks
  property p_en_off;
    @(posedge core_clk) disable iff (!resetn)
      !en_s |=> (out_drive == 4'h0 && !(|(hit_gnd | hit_sup | hit_open)));
  endproperty
  a_en_off: assert property (p_en_off) else $error("drive or filter active while disabled");

  property p_uv_off;
    @(posedge core_clk) disable iff (!resetn)
      uv_s |=> (out_drive == 4'h0);
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("output on during undervoltage");

  property p_cmd_on;
    @(posedge core_clk) disable iff (!resetn)
      (en_s && !uv_s && cmd_s[0] && !oc_s[0] && !oc_lat_q[0]) |=> out_drive[0];
  endproperty
  a_cmd_on: assert property (p_cmd_on) else $error("channel not switched on");

  property p_oc_hold;
    @(posedge core_clk) disable iff (!resetn)
      (oc_lat_q[1] && cmd_s[1] && !uv_s) |=> (oc_lat_q[1] && !out_drive[1]);
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("overcurrent latch released early");

  property p_therm_direct;
    @(posedge core_clk) disable iff (!resetn)
      therm_s[2] |=> diag_q[qdfd_pkg::diag_idx(2, qdfd_pkg::KIND_THERM)];
  endproperty
  a_therm_direct: assert property (p_therm_direct) else $error("thermal bit not set");

  property p_filter_gap;
    @(posedge core_clk) disable iff (!resetn)
      (en_s && !gnd_s[3]) |=> !hit_gnd[3];
  endproperty
  a_filter_gap: assert property (p_filter_gap) else $error("filter hit without fault");

  property p_desel_keep;
    @(posedge core_clk) disable iff (!resetn)
      (cs_n_s && edge_q[2]) |=> ((diag_q & $past(diag_q)) == $past(diag_q));
  endproperty
  a_desel_keep: assert property (p_desel_keep) else $error("diag lost while deselected");

  property p_desel_release;
    @(posedge core_clk) disable iff (!resetn)
      cs_n_s |-> !serial_tx_pin_oe ##1 !sif.active;
  endproperty
  a_desel_release: assert property (p_desel_release) else $error("output driven while deselected");

  property p_irq_raise;
    @(posedge core_clk) disable iff (!resetn)
      (|(new_set & irqen_q) && !wr_acc) |=> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");

  property p_gnd_bit;
    @(posedge core_clk) disable iff (!resetn)
      hit_gnd[1] |=> diag_q[qdfd_pkg::diag_idx(1, qdfd_pkg::KIND_GND)];
  endproperty
  a_gnd_bit: assert property (p_gnd_bit) else $error("ground short bit not set");
endmodule
